/* dpr_ctrl.sv */
/*
  Drive protection and restart controller: thermal overload models for two motors,
  automatic restart counting within a fault window, speed search selection and
  momentary power loss handling, with an APB register slave.
  Assumes all drive inputs are synchronous to ref_clk_i and the APB master follows APB3.
*/
`timescale 1ns/100ps

// Function
// [R1] Motor 1 model: 0 CT, 1 VT, 2 off.
// [R2] CT allows 100 percent, 150 percent one minute.
// [R3] VT limit is 1.2 percent per Hz plus 40.
// [R4] Motor 1 thermal time 30 to 600 s.
// [R5] Default time gives 60 s at 150 percent.
// [R6] Trip time scales with thermal time over 60.
// [R7] Trip flags motor overload and removes output.
// [R8] Motor 2 model same encoding, default off.
// [R9] Motor 2 thermal time same as motor 1.
// [R10] Restart limit 0 to 10, default 0.
// [R11] Only overcurrent, overvoltage, short circuit restart.
// [R12] Limit zero means no automatic restart.
// [R13] Speed search per after-fault selector before restart.
// [R14] Count above limit locks until reset key.
// [R15] Window expiry clears the fault count.
// [R16] Fault window 0 to 6000 s, default 60.
// [R17] After-fault search: off, speed reference, minimum.
// [R18] Configuring party sets nonzero limit for restarts.
// [R19] Start search: off, maximum, start-up, minimum.
// [R20] Ride-through: off, last command, minimum frequency.
// [R21] Ride-through enabled resumes after supply returns.
// [R22] Ride-through off stops after power loss.
// [R23] Window starts at first fault, count compared inside.
module dpr_ctrl
  import dpr_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic           ref_clk_i,
  input  wire logic           rst_n_i,
  // APB slave.
  input  wire logic           psel_i,
  input  wire logic           penable_i,
  input  wire logic           pwrite_i,
  input  wire logic [15:0]    paddr_i,
  input  wire logic [31:0]    pwdata_i,
  output logic      [31:0]    prdata_o,
  output logic                pready_o,
  output logic                pslverr_o,
  // Power stage and fault detectors.
  input  wire dpr_drive_in_t  drv_i,
  output dpr_drive_out_t      drv_o
);

  typedef struct packed {
    dpr_cfg_t         cfg;
    dpr_state_t       st;
    logic [3:0]       fault_cnt;
    logic             win_open;
    logic [15:0]      win_cnt;
    logic [19:0]      tick_cnt;
    logic [1:0][31:0] heat;
    logic [1:0]       ol_fault;
    logic             search_req;
    logic [2:0]       search_mode;
    logic             auto_restart;
    logic [31:0]      prdata;
    logic             slverr;
  } dpr_regs_t;

  localparam logic [19:0] TICK_LAST = 20'(TICK_LEN - 1);

  dpr_regs_t   q;
  dpr_regs_t   d;
  logic        tick;
  logic [31:0] vt_raw;
  logic [15:0] vt_lim;
  logic [1:0][15:0] lim;
  logic [1:0][31:0] thr;
  logic [1:0]  trip;
  logic        eligible;
  logic [3:0]  cnt_next;
  logic [13:0] idx;
  logic        idx_ok;
  logic        val_ok;
  logic [15:0] wval;
  logic [15:0] rval;

  function automatic logic [2:0] af_mode(input logic [15:0] sel);
    case (sel)
      16'h0001: af_mode = SRCH_SPEEDREF;
      16'h0002: af_mode = SRCH_MINFREQ;
      default:  af_mode = SRCH_NONE;
    endcase
  endfunction

  function automatic logic [2:0] start_mode(input logic [15:0] sel);
    case (sel)
      16'h0001: start_mode = SRCH_MAXFREQ;
      16'h0002: start_mode = SRCH_STARTUP;
      16'h0003: start_mode = SRCH_MINFREQ;
      default:  start_mode = SRCH_NONE;
    endcase
  endfunction

  function automatic logic [2:0] ride_mode(input logic [15:0] sel);
    case (sel)
      16'h0001: ride_mode = SRCH_LASTCMD;
      16'h0002: ride_mode = SRCH_MINFREQ;
      default:  ride_mode = SRCH_NONE;
    endcase
  endfunction

  // Variable-torque derating, capped at full rated current.
  assign vt_raw = (32'(drv_i.out_freq) * 32'(VT_SLOPE)) / 32'(FREQ_SCALE)
                  + 32'(VT_BASE);  // see [R3]
  assign vt_lim = (vt_raw > 32'(FULL_PCT)) ? FULL_PCT : vt_raw[15:0];

  // Per-motor allowed current and trip threshold.
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      lim[m] = (q.cfg.ol_model[m] == MODEL_VT) ? vt_lim : FULL_PCT;  // see [R2] see [R3]
      // At 150 percent of the limit the excess is half the limit per tick.
      thr[m] = (32'(lim[m]) * 32'(q.cfg.therm_time[m])) >> 1;  // see [R5] see [R6] see [R9]
      trip[m] = (q.cfg.ol_model[m] != MODEL_OFF) && (q.heat[m] >= thr[m]);  // see [R1] see [R8]
    end
  end

  assign eligible = drv_i.overcurrent_fault | drv_i.overvoltage_fault
                    | drv_i.short_circuit_fault;  // see [R11]
  assign cnt_next = !q.win_open ? 4'h1 : (q.fault_cnt == 4'hF) ? 4'hF : q.fault_cnt + 4'h1;

  // Register decode and write range check.
  assign idx    = paddr_i[15:2];
  assign wval   = pwdata_i[15:0];
  assign idx_ok = (paddr_i[1:0] == 2'b00)
                  && (((idx >= IDX_OL_MODEL_1) && (idx <= IDX_RIDE_SEL)) || (idx == IDX_STATUS));

  always_comb begin
    val_ok = 1'b0;
    rval   = 16'h0000;
    case (idx)
      IDX_OL_MODEL_1: begin
        val_ok = wval <= MODEL_OFF;  // see [R1]
        rval   = q.cfg.ol_model[0];
      end
      IDX_OL_MODEL_2: begin
        val_ok = wval <= MODEL_OFF;  // see [R8]
        rval   = q.cfg.ol_model[1];
      end
      IDX_THERM_TIME_1: begin
        val_ok = (wval >= THERM_MIN) && (wval <= THERM_MAX);  // see [R4]
        rval   = q.cfg.therm_time[0];
      end
      IDX_THERM_TIME_2: begin
        val_ok = (wval >= THERM_MIN) && (wval <= THERM_MAX);  // see [R9]
        rval   = q.cfg.therm_time[1];
      end
      IDX_RESTART_LIM: begin
        val_ok = wval <= LIMIT_MAX;  // see [R10]
        rval   = q.cfg.restart_limit;
      end
      IDX_WINDOW_TIME: begin
        val_ok = wval <= WINDOW_MAX;  // see [R16]
        rval   = q.cfg.window_time;
      end
      IDX_AF_SEARCH: begin
        val_ok = wval <= AF_SEL_MAX;  // see [R17]
        rval   = q.cfg.after_fault_search_sel;
      end
      IDX_START_SEARCH: begin
        val_ok = wval <= START_SEL_MAX;  // see [R19]
        rval   = q.cfg.start_search_sel;
      end
      IDX_RIDE_SEL: begin
        val_ok = wval <= RIDE_SEL_MAX;  // see [R20]
        rval   = q.cfg.power_loss_ride_sel;
      end
      IDX_STATUS: begin
        val_ok = 1'b0;
        rval   = {q.st, q.win_open, q.fault_cnt, q.search_mode, 1'b0, q.ol_fault};
      end
      default: begin
        val_ok = 1'b0;
        rval   = 16'h0000;
      end
    endcase
  end

  always_comb begin
    d              = q;
    d.search_req   = 1'b0;
    d.auto_restart = 1'b0;
    tick           = (q.tick_cnt == TICK_LAST);
    d.tick_cnt     = tick ? 20'h00000 : q.tick_cnt + 20'h00001;

    // Bus: the answer is prepared in the setup cycle, the write lands in the access cycle.
    if (psel_i && !penable_i) begin
      d.prdata = (idx_ok && !pwrite_i) ? {16'h0000, rval} : 32'h00000000;
      d.slverr = !idx_ok || (pwrite_i && !val_ok);
    end
    if (psel_i && penable_i && pwrite_i && !q.slverr) begin
      case (idx)
        IDX_OL_MODEL_1:   d.cfg.ol_model[0]             = wval;
        IDX_OL_MODEL_2:   d.cfg.ol_model[1]             = wval;
        IDX_THERM_TIME_1: d.cfg.therm_time[0]           = wval;
        IDX_THERM_TIME_2: d.cfg.therm_time[1]           = wval;
        IDX_RESTART_LIM:  d.cfg.restart_limit           = wval;
        IDX_WINDOW_TIME:  d.cfg.window_time             = wval;
        IDX_AF_SEARCH:    d.cfg.after_fault_search_sel  = wval;
        IDX_START_SEARCH: d.cfg.start_search_sel        = wval;
        IDX_RIDE_SEL:     d.cfg.power_loss_ride_sel     = wval;
        default:          d.cfg                         = q.cfg;
      endcase
    end

    // Thermal integration on the running motor; cools down while within its limit.
    for (int m = 0; m < 2; m++) begin
      if (q.cfg.ol_model[m] == MODEL_OFF) begin
        d.heat[m] = 32'h00000000;
      end else if (tick && (q.st == ST_RUN) && (drv_i.motor_sel == m[0])) begin
        if (drv_i.motor_current > lim[m]) begin
          d.heat[m] = q.heat[m] + 32'(drv_i.motor_current - lim[m]);  // see [R2] see [R6]
        end else if (q.heat[m] > 32'(lim[m] - drv_i.motor_current)) begin
          d.heat[m] = q.heat[m] - 32'(lim[m] - drv_i.motor_current);
        end else begin
          d.heat[m] = 32'h00000000;
        end
      end
    end

    // Fault window: opens at the first eligible fault and clears the count on expiry.
    if (q.win_open && tick) begin
      if (q.win_cnt >= q.cfg.window_time) begin
        d.win_open  = 1'b0;  // see [R23]
        d.fault_cnt = 4'h0;  // see [R15]
      end else begin
        d.win_cnt = q.win_cnt + 16'h0001;
      end
    end

    unique case (q.st)
      ST_IDLE: begin
        if (drv_i.start_cmd) begin
          d.st          = ST_RESTART;
          d.search_req  = start_mode(q.cfg.start_search_sel) != SRCH_NONE;  // see [R19]
          d.search_mode = start_mode(q.cfg.start_search_sel);
        end
      end
      ST_RUN: begin
        if (trip != 2'b00) begin
          d.ol_fault = q.ol_fault | trip;  // see [R7]
          d.st       = ST_LOCK;
        end else if (eligible) begin
          d.fault_cnt = cnt_next;
          d.win_open  = 1'b1;  // see [R23]
          if (!q.win_open) begin
            d.win_cnt = 16'h0000;
          end
          if ((q.cfg.restart_limit == 16'h0000)
              || (16'(cnt_next) > q.cfg.restart_limit)) begin
            d.st = ST_LOCK;  // see [R12] see [R14] see [R18]
          end else begin
            d.st           = ST_RESTART;
            d.auto_restart = 1'b1;
            d.search_req   = af_mode(q.cfg.after_fault_search_sel) != SRCH_NONE;  // see [R13]
            d.search_mode  = af_mode(q.cfg.after_fault_search_sel);
          end
        end else if (!drv_i.supply_ok) begin
          d.st = (q.cfg.power_loss_ride_sel == RST_SEL) ? ST_IDLE : ST_LOSS;  // see [R22]
        end else if (drv_i.output_blocked_event) begin
          d.st          = ST_RESTART;
          d.search_req  = af_mode(q.cfg.after_fault_search_sel) != SRCH_NONE;  // see [R17]
          d.search_mode = af_mode(q.cfg.after_fault_search_sel);
        end
      end
      ST_RESTART: begin
        d.st = ST_RUN;
      end
      ST_LOSS: begin
        if (drv_i.supply_ok) begin
          d.st          = ST_RESTART;  // see [R21]
          d.search_req  = 1'b1;
          d.search_mode = ride_mode(q.cfg.power_loss_ride_sel);  // see [R20]
        end
      end
      ST_LOCK: begin
        if (drv_i.reset_key) begin
          d.st        = ST_IDLE;  // see [R14]
          d.ol_fault  = 2'b00;
          d.fault_cnt = 4'h0;
          d.win_open  = 1'b0;
        end
      end
      default: begin
        d.st = ST_LOCK;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q                            <= '0;
      q.st                         <= ST_IDLE;
      q.cfg.ol_model[0]            <= RST_OL_MODEL_1;  // see [R1]
      q.cfg.ol_model[1]            <= RST_OL_MODEL_2;  // see [R8]
      q.cfg.therm_time[0]          <= RST_THERM_TIME;  // see [R4]
      q.cfg.therm_time[1]          <= RST_THERM_TIME;  // see [R9]
      q.cfg.restart_limit          <= RST_LIMIT;  // see [R10]
      q.cfg.window_time            <= RST_WINDOW;  // see [R16]
      q.cfg.after_fault_search_sel <= RST_SEL;
      q.cfg.start_search_sel       <= RST_SEL;
      q.cfg.power_loss_ride_sel    <= RST_SEL;
    end else begin
      q <= d;
    end
  end

  assign pready_o                    = 1'b1;
  assign prdata_o                    = q.prdata;
  assign pslverr_o                   = psel_i & penable_i & q.slverr;
  assign drv_o.output_enable         = (q.st == ST_RUN);  // see [R7]
  assign drv_o.motor1_overload_fault = q.ol_fault[0];
  assign drv_o.motor2_overload_fault = q.ol_fault[1];
  assign drv_o.locked                = (q.st == ST_LOCK);
  assign drv_o.search_req            = q.search_req;
  assign drv_o.search_mode           = q.search_mode;
  assign drv_o.auto_restart          = q.auto_restart;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_ZERO_LIMIT_LOCKS: assert property ( // see [R12]
    (q.st == ST_RUN) && (trip == 2'b00) && eligible && (q.cfg.restart_limit == 16'h0000)
    |=> (q.st == ST_LOCK) && !drv_o.output_enable
  ) else $error("Fault with zero restart limit did not lock.");

  AST_LOCK_HOLDS: assert property ( // see [R14]
    (q.st == ST_LOCK) && !drv_i.reset_key |=> (q.st == ST_LOCK)
  ) else $error("Lock released without reset key.");

  AST_TRIP_REMOVES_OUTPUT: assert property ( // see [R7]
    $rose(q.ol_fault[0]) || $rose(q.ol_fault[1]) |-> drv_o.locked && !drv_o.output_enable
  ) else $error("Overload trip left output enabled.");

  AST_AUTO_RESTART_SEARCH: assert property ( // see [R13]
    q.auto_restart |-> (q.search_mode == af_mode(q.cfg.after_fault_search_sel))
    ##1 (q.st == ST_RUN)
  ) else $error("Automatic restart used wrong search or did not run.");

  AST_NO_RIDE_STOPS: assert property ( // see [R22]
    (q.st == ST_RUN) && (trip == 2'b00) && !eligible && !drv_i.supply_ok
    && (q.cfg.power_loss_ride_sel == RST_SEL) |=> (q.st == ST_IDLE)
  ) else $error("Power loss with ride-through off did not stop.");

  AST_RIDE_RESUMES: assert property ( // see [R21]
    (q.st == ST_LOSS) && drv_i.supply_ok |=> q.search_req ##1 (q.st == ST_RUN)
  ) else $error("Supply return did not resume running.");

  AST_CFG_RANGES: assert property ( // see [R10]
    (q.cfg.restart_limit <= LIMIT_MAX) && (q.cfg.window_time <= WINDOW_MAX)
    && (q.cfg.therm_time[0] >= THERM_MIN) && (q.cfg.therm_time[0] <= THERM_MAX)
    && (q.cfg.therm_time[1] >= THERM_MIN) && (q.cfg.therm_time[1] <= THERM_MAX)
  ) else $error("Configuration left its legal range.");

  AST_WINDOW_CLEARS: assert property ( // see [R15]
    q.win_open && tick && (q.win_cnt >= q.cfg.window_time) && !eligible
    |=> !q.win_open && (q.fault_cnt == 4'h0)
  ) else $error("Fault window expiry did not clear the count.");

  AST_VT_LIMIT: assert property ( // see [R3]
    (q.cfg.ol_model[0] == MODEL_VT) |-> (lim[0] >= VT_BASE) && (lim[0] <= FULL_PCT)
  ) else $error("Variable-torque limit outside its bounds.");

  COV_AUTO_RESTART: cover property (q.auto_restart ##1 (q.st == ST_RUN));
  COV_LOCK_RELEASE: cover property ((q.st == ST_LOCK) ##1 (q.st == ST_IDLE));
  COV_RIDE_THROUGH: cover property ((q.st == ST_LOSS) ##1 (q.st == ST_RESTART));
  COV_OVERLOAD:     cover property ($rose(q.ol_fault[0]));

endmodule

/* dpr_pkg.sv */
/*
  Constants, encodings and carrier types for the drive protection and restart controller.
  Assumes a 10 MHz clock and 32-bit APB data with one register per aligned word.
*/
package dpr_pkg;

  // Clock and time base; all times are held in 0.1 s ticks.
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TICK_MS      = 100;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

  // Register indexes; the byte address is four times the index.
  localparam logic [13:0] IDX_OL_MODEL_1   = 14'h0600;
  localparam logic [13:0] IDX_THERM_TIME_1 = 14'h0601;
  localparam logic [13:0] IDX_OL_MODEL_2   = 14'h0602;
  localparam logic [13:0] IDX_THERM_TIME_2 = 14'h0603;
  localparam logic [13:0] IDX_RESTART_LIM  = 14'h0604;
  localparam logic [13:0] IDX_WINDOW_TIME  = 14'h0605;
  localparam logic [13:0] IDX_AF_SEARCH    = 14'h0606;
  localparam logic [13:0] IDX_START_SEARCH = 14'h0607;
  localparam logic [13:0] IDX_RIDE_SEL     = 14'h0608;
  localparam logic [13:0] IDX_STATUS       = 14'h0610;

  // Overload model encodings.
  localparam logic [15:0] MODEL_CT  = 16'h0000;
  localparam logic [15:0] MODEL_VT  = 16'h0001;
  localparam logic [15:0] MODEL_OFF = 16'h0002;

  // Reset values and legal ranges.
  localparam logic [15:0] RST_OL_MODEL_1 = 16'h0001;
  localparam logic [15:0] RST_OL_MODEL_2 = 16'h0002;
  localparam logic [15:0] RST_THERM_TIME = 16'h0258;
  localparam logic [15:0] THERM_MIN      = 16'h012C;
  localparam logic [15:0] THERM_MAX      = 16'h1770;
  localparam logic [15:0] RST_LIMIT      = 16'h0000;
  localparam logic [15:0] LIMIT_MAX      = 16'h000A;
  localparam logic [15:0] RST_WINDOW     = 16'h0258;
  localparam logic [15:0] WINDOW_MAX     = 16'hEA60;
  localparam logic [15:0] RST_SEL        = 16'h0000;
  localparam logic [15:0] AF_SEL_MAX     = 16'h0002;
  localparam logic [15:0] START_SEL_MAX  = 16'h0003;
  localparam logic [15:0] RIDE_SEL_MAX   = 16'h0002;

  // Current limits in 0.1 % of rated current; frequency in 0.01 Hz.
  localparam logic [15:0] FULL_PCT   = 16'h03E8;
  localparam logic [15:0] VT_BASE    = 16'h0190;
  localparam logic [15:0] VT_SLOPE   = 16'h000C;
  localparam logic [15:0] FREQ_SCALE = 16'h0064;

  // Speed search start points requested of the power stage.
  localparam logic [2:0] SRCH_NONE     = 3'h0;
  localparam logic [2:0] SRCH_SPEEDREF = 3'h1;
  localparam logic [2:0] SRCH_MINFREQ  = 3'h2;
  localparam logic [2:0] SRCH_MAXFREQ  = 3'h3;
  localparam logic [2:0] SRCH_STARTUP  = 3'h4;
  localparam logic [2:0] SRCH_LASTCMD  = 3'h5;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_RUN     = 5'b00010,
    ST_RESTART = 5'b00100,
    ST_LOSS    = 5'b01000,
    ST_LOCK    = 5'b10000
  } dpr_state_t;

  typedef struct packed {
    logic [1:0][15:0] ol_model;
    logic [1:0][15:0] therm_time;
    logic [15:0]      restart_limit;
    logic [15:0]      window_time;
    logic [15:0]      after_fault_search_sel;
    logic [15:0]      start_search_sel;
    logic [15:0]      power_loss_ride_sel;
  } dpr_cfg_t;

  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] motor_current;
    logic        motor_sel;
    logic        overcurrent_fault;
    logic        overvoltage_fault;
    logic        short_circuit_fault;
    logic        output_blocked_event;
    logic        supply_ok;
    logic        start_cmd;
    logic        reset_key;
  } dpr_drive_in_t;

  typedef struct packed {
    logic       output_enable;
    logic       motor1_overload_fault;
    logic       motor2_overload_fault;
    logic       locked;
    logic       search_req;
    logic [2:0] search_mode;
    logic       auto_restart;
  } dpr_drive_out_t;

endpackage

/* dpr_stage_model.sv */
/*
  Behavioural power stage and fault detectors facing the protection controller.
  Assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/100ps
module dpr_stage_model
  import dpr_pkg::*;
(
  // Clock.
  input  wire logic           ref_clk_i,
  // Controller outputs.
  input  wire dpr_drive_out_t ctrl_i,
  // Stage and detector signals.
  output dpr_drive_in_t       drv_o
);
  logic [15:0] frq_set;
  logic [15:0] cur_set;
  logic        sel_set;

  initial begin
    drv_o = '0;
    drv_o.supply_ok = 1'b1;
    frq_set = '0;
    cur_set = '0;
    sel_set = 1'b0;
  end

  // A coasting motor draws no current and shows no output frequency.
  always @(posedge ref_clk_i) begin
    drv_o.out_freq      <= ctrl_i.output_enable ? frq_set : 16'h0000;
    drv_o.motor_current <= ctrl_i.output_enable ? cur_set : 16'h0000;
    drv_o.motor_sel     <= sel_set;
  end

  task automatic load(input logic [15:0] f, input logic [15:0] c, input logic s);
    frq_set = f;
    cur_set = c;
    sel_set = s;
  endtask

  // Raises faults, blocked event, start or reset key for one clock.
  task automatic pulse(input logic [5:0] m);
    @(posedge ref_clk_i);
    {drv_o.overcurrent_fault, drv_o.overvoltage_fault, drv_o.short_circuit_fault,
     drv_o.output_blocked_event, drv_o.start_cmd, drv_o.reset_key} <= m;
    @(posedge ref_clk_i);
    {drv_o.overcurrent_fault, drv_o.overvoltage_fault, drv_o.short_circuit_fault,
     drv_o.output_blocked_event, drv_o.start_cmd, drv_o.reset_key} <= 6'h00;
  endtask

  task automatic supply(input logic b);
    @(posedge ref_clk_i);
    drv_o.supply_ok <= b;
  endtask
endmodule

/* drive_protection_restart_ctrl_tb.sv */
/*
  Self-checking bench for the protection and restart controller.
  Assumes a short tick parameter so that overload and window times stay brief.
*/
`timescale 1ns/100ps
module drive_protection_restart_ctrl_tb;
  import dpr_pkg::*;
  logic           ref_clk_i = 1'b0;
  logic           rst_n_i;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [15:0]    paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic [33:0]    ae;
  dpr_drive_in_t  drv_i;
  dpr_drive_out_t drv_o;
  logic [33:0]    apb_q[$];
  logic [2:0]     srch_q[$];
  int             n_fail    = 0;
  int             n_checks  = 0;
  int             n_auto    = 0;
  logic [13:0]    idx_t[9]  = '{IDX_OL_MODEL_1, IDX_THERM_TIME_1, IDX_OL_MODEL_2,
    IDX_THERM_TIME_2, IDX_RESTART_LIM, IDX_WINDOW_TIME, IDX_AF_SEARCH, IDX_START_SEARCH,
    IDX_RIDE_SEL};
  logic [15:0]    rst_t[9]  = '{RST_OL_MODEL_1, RST_THERM_TIME, RST_OL_MODEL_2,
    RST_THERM_TIME, RST_LIMIT, RST_WINDOW, RST_SEL, RST_SEL, RST_SEL};

  always #50 ref_clk_i = ~ref_clk_i;

  dpr_ctrl #(.TICK_LEN(10)) u_dpr_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .drv_i(drv_i), .drv_o(drv_o));
  dpr_stage_model u_dpr_stage_model (.ref_clk_i(ref_clk_i), .ctrl_i(drv_o), .drv_o(drv_i));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Notes the expected answer, then runs one setup and access phase.
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d,
                     input logic e);
    apb_q.push_back({!w && !e, e, d});
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1) @(posedge ref_clk_i);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Takes the oldest note whenever a transfer or a search request shows.
  always @(posedge ref_clk_i) begin
    if (psel && penable && pready === 1'b1) begin
      ae = apb_q.pop_front();
      chk("pslverr", 32'(pslverr), 32'(ae[32]));
      if (ae[33]) chk("prdata", prdata, ae[31:0]);
    end
    if (drv_o.auto_restart === 1'b1) n_auto++;
    if (drv_o.search_req === 1'b1)
      chk("search_mode", 32'(drv_o.search_mode), 32'(srch_q.pop_front()));
  end

  task automatic wait_oe;
    int k;
    k = 0;
    while (drv_o.output_enable !== 1'b1 && k < 50) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk("output_enable", 32'(drv_o.output_enable), 32'h1);
  endtask

  task automatic run_up;
    u_dpr_stage_model.pulse(6'h02);
    wait_oe;
  endtask

  task automatic settle;
    repeat (3) @(negedge ref_clk_i);
  endtask

  initial begin
    #2_000_000;
    n_fail++;
    wrap_up;
  end

  initial begin
    int k;
    int n;
    logic [15:0] v;
    logic [1:0] fl;
    rst_n_i <= 1'b0;
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    v = 16'($urandom(32'h4418));
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (k = 0; k < 9; k++) begin
      apb(0, idx_t[k], 32'(rst_t[k]), 0);
    end
    apb(0, 14'h0700, 32'h0, 1);
    $display("Test reset values done");
    apb(1, IDX_RESTART_LIM, 32'h0000000B, 1);
    apb(1, IDX_RESTART_LIM, 32'(LIMIT_MAX), 0);
    apb(0, IDX_RESTART_LIM, 32'(LIMIT_MAX), 0);
    apb(1, IDX_THERM_TIME_2, 32'h0000012B, 1);
    apb(1, IDX_THERM_TIME_2, 32'h00001771, 1);
    v = 16'(300 + $urandom % 5701);
    apb(1, IDX_THERM_TIME_1, 32'(v), 0);
    apb(0, IDX_THERM_TIME_1, 32'(v), 0);
    v = 16'($urandom % 60001);
    apb(1, IDX_WINDOW_TIME, 32'(v), 0);
    apb(0, IDX_WINDOW_TIME, 32'(v), 0);
    apb(1, IDX_WINDOW_TIME, 32'h0000EA61, 1);
    apb(1, IDX_OL_MODEL_1, 32'h00000003, 1);
    apb(1, IDX_OL_MODEL_2, 32'h00000003, 1);
    apb(1, IDX_AF_SEARCH, 32'h00000003, 1);
    apb(1, IDX_START_SEARCH, 32'h00000004, 1);
    apb(1, IDX_RIDE_SEL, 32'h00000003, 1);
    $display("Test ranges done");
    for (k = 1; k < 4; k++) begin
      apb(1, IDX_START_SEARCH, 32'(k), 0);
      srch_q.push_back(k == 1 ? SRCH_MAXFREQ : k == 2 ? SRCH_STARTUP : SRCH_MINFREQ);
      run_up;
      u_dpr_stage_model.supply(1'b0);
      settle;
      chk("stopped", 32'({drv_o.output_enable, drv_o.locked}), 32'h0);
      u_dpr_stage_model.supply(1'b1);
    end
    apb(1, IDX_START_SEARCH, 32'h0, 0);
    $display("Test start search done");
    run_up;
    for (k = 1; k < 3; k++) begin
      apb(1, IDX_RIDE_SEL, 32'(k), 0);
      srch_q.push_back(k == 1 ? SRCH_LASTCMD : SRCH_MINFREQ);
      u_dpr_stage_model.supply(1'b0);
      settle;
      chk("output_enable", 32'(drv_o.output_enable), 32'h0);
      u_dpr_stage_model.supply(1'b1);
      wait_oe;
    end
    $display("Test ride through done");
    apb(1, IDX_RESTART_LIM, 32'h2, 0);
    apb(1, IDX_AF_SEARCH, 32'h1, 0);
    apb(1, IDX_WINDOW_TIME, 32'h5, 0);
    for (k = 0; k < 3; k++) begin
      if (k < 2) srch_q.push_back(SRCH_SPEEDREF);
      u_dpr_stage_model.pulse(6'h20 >> k);
      settle;
      chk("locked", 32'(drv_o.locked), 32'(k == 2));
    end
    repeat (100) @(negedge ref_clk_i);
    u_dpr_stage_model.pulse(6'h01);
    run_up;
    srch_q.push_back(SRCH_SPEEDREF);
    u_dpr_stage_model.pulse(6'h20);
    settle;
    chk("locked", 32'(drv_o.locked), 32'h0);
    srch_q.push_back(SRCH_SPEEDREF);
    u_dpr_stage_model.pulse(6'h04);
    settle;
    chk("output_enable", 32'(drv_o.output_enable), 32'h1);
    apb(1, IDX_AF_SEARCH, 32'h2, 0);
    repeat (100) @(negedge ref_clk_i);
    for (k = 0; k < 2; k++) begin
      srch_q.push_back(SRCH_MINFREQ);
      u_dpr_stage_model.pulse(6'h20);
      settle;
      chk("locked", 32'(drv_o.locked), 32'h0);
    end
    apb(1, IDX_RESTART_LIM, 32'h0, 0);
    u_dpr_stage_model.pulse(6'h20);
    settle;
    chk("locked", 32'(drv_o.locked), 32'h1);
    u_dpr_stage_model.pulse(6'h01);
    $display("Test restart counting done");
    apb(1, IDX_THERM_TIME_1, 32'(THERM_MIN), 0);
    apb(1, IDX_THERM_TIME_2, 32'(THERM_MIN), 0);
    apb(1, IDX_OL_MODEL_2, 32'(MODEL_CT), 0);
    for (k = 0; k < 3; k++) begin
      apb(1, IDX_OL_MODEL_1, 32'(MODEL_OFF), 0);
      apb(1, IDX_OL_MODEL_1, 32'(k == 1 ? MODEL_VT : MODEL_CT), 0);
      u_dpr_stage_model.load(16'h09C4, k == 1 ? 16'h041A : 16'h05DC, k == 2);
      run_up;
      n = 0;
      while (drv_o.locked !== 1'b1 && n < 4000) begin
        @(negedge ref_clk_i);
        n++;
      end
      fl = {drv_o.motor2_overload_fault, drv_o.motor1_overload_fault};
      chk("trip_time", 32'(n >= 2950 && n <= 3050), 32'h1);
      chk("ol_flags", 32'(fl), 32'(k == 2 ? 2 : 1));
      chk("output_enable", 32'(drv_o.output_enable), 32'h0);
      u_dpr_stage_model.pulse(6'h01);
    end
    u_dpr_stage_model.load(16'h0000, 16'h0000, 1'b0);
    $display("Test overload done");
    chk("search_left", 32'(srch_q.size()), 32'h0);
    chk("auto_restart", 32'(n_auto), 32'h5);
    wrap_up;
  end
endmodule
